// *** verilog/timer8_pkg.sv ***
// Package with register map, field layout, modes and prescaler taps of the 8-bit timer
package timer8_pkg;

    // Register offsets on the plain register port
    localparam logic [2:0] OFS_CONTROL = 3'h0;
    localparam logic [2:0] OFS_COUNT = 3'h1;
    localparam logic [2:0] OFS_COMPARE = 3'h2;
    localparam logic [2:0] OFS_FLAGS = 3'h3;
    localparam logic [2:0] OFS_MASK = 3'h4;
    localparam logic [2:0] OFS_ASYNC = 3'h5;

    // Field positions in the control register
    localparam int WAVE_LO_POS = 0;
    localparam int WAVE_HI_POS = 1;
    localparam int COM_LO_POS = 2;
    localparam int COM_HI_POS = 3;
    localparam int CS_LO_POS = 4;
    localparam int CS_HI_POS = 6;
    localparam int FORCE_POS = 7;

    // Field positions in flag, mask and async status registers
    localparam int OVF_POS = 0;
    localparam int CMP_POS = 1;
    localparam int ASYNC_SEL_POS = 0;

    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COMPARE_RST = 8'h00;
    localparam logic [1:0] FLAGS_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic ASYNC_SEL_RST = 1'b0;

    // Count extremes
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    // Wave mode codes
    localparam logic [1:0] WAVE_NORMAL = 2'h0;
    localparam logic [1:0] WAVE_PHASE_PWM = 2'h1;
    localparam logic [1:0] WAVE_CTC = 2'h2;
    localparam logic [1:0] WAVE_FAST_PWM = 2'h3;

    // Compare output mode codes
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    // Prescaler width and tap masks per clock select code (code 0 stops the timer)
    localparam int PRESCALE_W = 10;
    localparam logic [2:0] CS_STOPPED = 3'h0;
    localparam logic [9:0] TAP_DIV1 = 10'h000;
    localparam logic [9:0] TAP_DIV8 = 10'h007;
    localparam logic [9:0] TAP_DIV32 = 10'h01f;
    localparam logic [9:0] TAP_DIV64 = 10'h03f;
    localparam logic [9:0] TAP_DIV128 = 10'h07f;
    localparam logic [9:0] TAP_DIV256 = 10'h0ff;
    localparam logic [9:0] TAP_DIV1024 = 10'h3ff;

endpackage

// *** verilog/pin_sampler.sv ***
// Three-stage sampler for a pin input with an agreement filter and rising-edge pulse
`timescale 1ns/100ps
`default_nettype none
module pin_sampler (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Raw pin
    input wire logic i_pin,
    // Filtered level and its rising edge
    output logic o_level,
    output logic o_rise
);

    logic meta;
    logic stage2;
    logic stage3;

    // Plain shift chain; the first stage feeds only the second
    always_ff @(posedge i_clk) begin
        meta <= i_pin;
        stage2 <= meta;
        stage3 <= stage2;
    end

    // A change counts only once the second and third stages agree
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_level <= 1'b0;
            o_rise <= 1'b0;
        end else begin
            o_rise <= 1'b0;
            if (stage2 == stage3) begin
                o_level <= stage3;
                o_rise <= stage3 & ~o_level;
            end
        end
    end

endmodule
`default_nettype wire

// *** verilog/async_timer8_compare_unit.sv ***
// 8-bit timer/counter with clock select, prescaler and one output compare unit
//
// Contract
// RULE1 - Count and compare values are 8-bit registers
// RULE2 - Clock from io clock, or crystal when selected
// RULE3 - Clock select zero stops the counter
// RULE4 - Count value readable and writable anytime
// RULE5 - Count write beats clear or count
// RULE6 - Bottom indication when count becomes zero
// RULE7 - Max indication when count becomes 255
// RULE8 - Top is 255 or compare value by mode
// RULE9 - Each tick clears, increments or decrements
// RULE10 - Wave mode bits set the count sequence
// RULE11 - Overflow flag set per mode, interrupt source
// RULE12 - Comparator signals equality of count and compare
// RULE13 - Match sets flag on next tick
// RULE14 - Enabled compare flag raises interrupt request
// RULE15 - Flag clears on service or written one
// RULE16 - Output follows match, wave mode, output mode
// RULE17 - Max and bottom feed waveform special cases
// RULE18 - Requests visible in flags, individually masked
// RULE19 - Comparator uses the buffered compare value
// RULE20 - Buffering only in pulse width modes
// RULE21 - Count write blocks match on next tick
// RULE22 - Forced strobe updates output, no flag or clear
// RULE23 - Flag set beats software clear
// RULE24 - Nonzero select picks a prescaler tap
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module async_timer8_compare_unit
    import timer8_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Interrupt service acknowledges and requests
    input wire logic i_ovf_service,
    input wire logic i_cmp_service,
    output logic o_ovf_irq,
    output logic o_cmp_irq,
    // Crystal oscillator pins
    input wire logic i_crystal_pin_in,
    output logic o_crystal_pin_out,
    // Compare output and its port override
    output logic o_compare_output,
    output logic o_compare_output_en
);

    // Software state
    logic [1:0] wave_mode_field;
    logic [1:0] compare_output_mode;
    logic [2:0] clock_select_field;
    logic async_clock_select;
    logic [7:0] count_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    logic [1:0] timer_flag_reg;
    logic [1:0] timer_irq_mask_reg;

    // Counter core state
    logic count_down;
    logic match_blocked;
    logic [PRESCALE_W-1:0] prescale;
    logic crystal_level;
    logic crystal_rise;

    // Decoded strobes and combinational results
    logic wr_control;
    logic wr_count;
    logic wr_compare;
    logic wr_flags;
    logic force_strobe;
    logic source_tick;
    logic timer_tick;
    logic [9:0] tap_mask;
    logic pwm_mode;
    logic at_max;
    logic at_bottom;
    logic at_top;
    logic compare_match;
    logic match_event;
    logic [7:0] next_count;
    logic next_down;
    logic ovf_event;
    logic [1:0] next_flags;
    logic next_output;

    // Register write decode, shared by every write path
    function automatic logic hit(input logic [2:0] ofs);
        hit = i_wr && (i_addr == ofs);
    endfunction

    // Output action for a compare event in the non-pulse-width modes
    function automatic logic com_action(input logic [1:0] com, input logic cur);
        unique case (com)
            COM_OFF: com_action = cur;
            COM_TOGGLE: com_action = ~cur;
            COM_CLEAR: com_action = 1'b0;
            COM_SET: com_action = 1'b1;
        endcase
    endfunction

    assign wr_control = hit(OFS_CONTROL);
    assign wr_count = hit(OFS_COUNT);
    assign wr_compare = hit(OFS_COMPARE);
    assign wr_flags = hit(OFS_FLAGS);
    // The force bit is a strobe and only acts outside the pulse width modes
    assign force_strobe = wr_control && i_wdata[FORCE_POS] && !pwm_mode;
    assign pwm_mode = (wave_mode_field == WAVE_PHASE_PWM) || (wave_mode_field == WAVE_FAST_PWM);

    // Crystal pin comes from outside this clock domain
    pin_sampler crystal_sampler (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_pin(i_crystal_pin_in),
        .o_level(crystal_level),
        .o_rise(crystal_rise)
    );

    // Inverting amplifier stand-in; keeps the oscillator loop closed
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_crystal_pin_out <= 1'b1;
        end else begin
            o_crystal_pin_out <= ~crystal_level;
        end
    end

    // Source is the io clock, or crystal rising edges when selected
    assign source_tick = async_clock_select ? crystal_rise : 1'b1; // see RULE2

    // Prescaler taps; the mapping of codes to ratios is a local choice
    always_comb begin
        unique case (clock_select_field)
            3'h1: tap_mask = TAP_DIV1;
            3'h2: tap_mask = TAP_DIV8;
            3'h3: tap_mask = TAP_DIV32;
            3'h4: tap_mask = TAP_DIV64;
            3'h5: tap_mask = TAP_DIV128;
            3'h6: tap_mask = TAP_DIV256;
            3'h7: tap_mask = TAP_DIV1024;
            default: tap_mask = TAP_DIV1; // Stopped anyway, see below
        endcase
    end

    // Prescaler runs on the chosen source, free of the select code
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            prescale <= '0;
        end else if (source_tick) begin
            prescale <= prescale + 10'h001; // see RULE24
        end
    end

    // Timer tick: none while the select code is zero
    assign timer_tick = source_tick && (clock_select_field != CS_STOPPED) // see RULE3
        && ((prescale & tap_mask) == tap_mask); // see RULE24

    // Extreme value and top indications
    assign at_max = (count_value == COUNT_MAX); // see RULE7
    assign at_bottom = (count_value == COUNT_BOTTOM); // see RULE6
    assign at_top = (wave_mode_field == WAVE_CTC) ? (count_value == compare_value) : at_max; // see RULE8

    // Comparator against the active compare value
    assign compare_match = (count_value == compare_value); // see RULE12 RULE19
    assign match_event = timer_tick && compare_match && !match_blocked; // see RULE21

    // Next count and direction per wave mode
    always_comb begin
        next_count = count_value;
        next_down = count_down;
        ovf_event = 1'b0;
        unique case (wave_mode_field) // see RULE10
            WAVE_PHASE_PWM: begin
                // Dual slope: turn at max going up and at bottom going down
                if (!count_down) begin
                    if (at_max) begin
                        next_down = 1'b1;
                        next_count = count_value - 8'h01; // see RULE9
                    end else begin
                        next_count = count_value + 8'h01;
                    end
                end else begin
                    if (at_bottom) begin
                        next_down = 1'b0;
                        next_count = count_value + 8'h01;
                    end else begin
                        next_count = count_value - 8'h01;
                    end
                end
                ovf_event = at_bottom; // see RULE11
            end
            WAVE_CTC: begin
                // Clear only on a match that is not blocked
                next_down = 1'b0;
                next_count = (at_top && !match_blocked) ? COUNT_BOTTOM : count_value + 8'h01; // see RULE9
                ovf_event = at_max;
            end
            default: begin
                // Normal and fast pulse width: single slope to max then wrap
                next_down = 1'b0;
                next_count = count_value + 8'h01;
                ovf_event = at_max; // see RULE11
            end
        endcase
    end

    // Control register; the force bit is never stored
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wave_mode_field <= CONTROL_RST[WAVE_HI_POS:WAVE_LO_POS];
            compare_output_mode <= CONTROL_RST[COM_HI_POS:COM_LO_POS];
            clock_select_field <= CONTROL_RST[CS_HI_POS:CS_LO_POS];
        end else if (wr_control) begin
            wave_mode_field <= i_wdata[WAVE_HI_POS:WAVE_LO_POS];
            compare_output_mode <= i_wdata[COM_HI_POS:COM_LO_POS];
            clock_select_field <= i_wdata[CS_HI_POS:CS_LO_POS];
        end
    end

    // Async status; switching source mid-count may give one odd tick
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            async_clock_select <= ASYNC_SEL_RST;
        end else if (hit(OFS_ASYNC)) begin
            async_clock_select <= i_wdata[ASYNC_SEL_POS]; // see RULE2
        end
    end

    // Mask register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            timer_irq_mask_reg <= MASK_RST;
        end else if (hit(OFS_MASK)) begin
            timer_irq_mask_reg <= i_wdata[CMP_POS:OVF_POS]; // see RULE18
        end
    end

    // Counter: a software write wins over any tick in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            count_value <= COUNT_RST;
            count_down <= 1'b0;
        end else if (wr_count) begin
            count_value <= i_wdata; // see RULE4 RULE5
        end else if (timer_tick) begin
            count_value <= next_count; // see RULE9
            count_down <= next_down;
        end
    end

    // A count write blocks the match on the following tick, even when stopped
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            match_blocked <= 1'b0;
        end else if (wr_count) begin
            match_blocked <= 1'b1; // see RULE21
        end else if (timer_tick) begin
            match_blocked <= 1'b0;
        end
    end

    // Software always writes the buffer
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            compare_buffer <= COMPARE_RST;
        end else if (wr_compare) begin
            compare_buffer <= i_wdata; // see RULE1
        end
    end

    // Active compare value: direct in non-pulse-width modes, else loaded at top
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            compare_value <= COMPARE_RST;
        end else if (!pwm_mode) begin
            compare_value <= wr_compare ? i_wdata : compare_buffer; // see RULE20
        end else if (timer_tick && at_max && !wr_count) begin
            compare_value <= compare_buffer; // see RULE19 RULE20
        end
    end

    // Flags: hardware set wins over a clear by service or written one
    always_comb begin
        next_flags = timer_flag_reg;
        if (wr_flags) begin
            next_flags = next_flags & ~i_wdata[CMP_POS:OVF_POS]; // see RULE15
        end
        if (i_ovf_service) begin
            next_flags[OVF_POS] = 1'b0;
        end
        if (i_cmp_service) begin
            next_flags[CMP_POS] = 1'b0; // see RULE15
        end
        if (timer_tick && !wr_count && ovf_event) begin
            next_flags[OVF_POS] = 1'b1; // see RULE11 RULE23
        end
        if (match_event) begin
            next_flags[CMP_POS] = 1'b1; // see RULE13 RULE23
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            timer_flag_reg <= FLAGS_RST;
        end else begin
            timer_flag_reg <= next_flags;
        end
    end

    // Requests follow flags through the mask
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_ovf_irq <= 1'b0;
            o_cmp_irq <= 1'b0;
        end else begin
            o_ovf_irq <= timer_flag_reg[OVF_POS] && timer_irq_mask_reg[OVF_POS]; // see RULE18
            o_cmp_irq <= timer_flag_reg[CMP_POS] && timer_irq_mask_reg[CMP_POS]; // see RULE14
        end
    end

    // Waveform generator next state
    always_comb begin
        next_output = o_compare_output;
        if (force_strobe) begin
            next_output = com_action(compare_output_mode, o_compare_output); // see RULE22
        end else if (timer_tick && !wr_count) begin
            unique case (wave_mode_field) // see RULE16
                WAVE_FAST_PWM: begin
                    // Match clears (or sets if inverted); wrap to bottom restores.
                    // A compare value of max matches at the wrap and keeps the level.
                    if (compare_output_mode[1]) begin
                        if (match_event) begin
                            next_output = compare_output_mode[0];
                        end else if (at_max) begin
                            next_output = ~compare_output_mode[0]; // see RULE17
                        end
                    end
                end
                WAVE_PHASE_PWM: begin
                    // Level depends on slope; of the turn points only bottom is used, for a compare value of bottom
                    if (compare_output_mode[1] && match_event) begin
                        next_output = compare_output_mode[0] ^ count_down;
                    end else if (compare_output_mode[1] && at_bottom && compare_value == COUNT_BOTTOM) begin
                        next_output = compare_output_mode[0]; // see RULE17
                    end
                end
                default: begin
                    if (match_event) begin
                        next_output = com_action(compare_output_mode, o_compare_output); // see RULE16
                    end
                end
            endcase
        end
    end

    // Compare output and override enable
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_compare_output <= 1'b0;
            o_compare_output_en <= 1'b0;
        end else begin
            o_compare_output <= next_output;
            o_compare_output_en <= (compare_output_mode != COM_OFF);
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                OFS_CONTROL: begin
                    o_rdata <= 8'h00;
                    o_rdata[WAVE_HI_POS:WAVE_LO_POS] <= wave_mode_field;
                    o_rdata[COM_HI_POS:COM_LO_POS] <= compare_output_mode;
                    o_rdata[CS_HI_POS:CS_LO_POS] <= clock_select_field;
                end
                OFS_COUNT: o_rdata <= count_value; // see RULE4
                OFS_COMPARE: o_rdata <= compare_buffer;
                OFS_FLAGS: o_rdata <= {6'h00, timer_flag_reg}; // see RULE18
                OFS_MASK: o_rdata <= {6'h00, timer_irq_mask_reg};
                OFS_ASYNC: o_rdata <= {7'h00, async_clock_select};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// *** verification/timer8_asserts.sv ***
// Concurrent checks on the register port and requests of the 8-bit timer
`timescale 1ns/100ps
`default_nettype none
module timer8_asserts
    import timer8_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Requests and port override
    input wire logic o_ovf_irq,
    input wire logic o_cmp_irq,
    input wire logic o_compare_output_en
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    logic [1:0] mask_sh;
    logic [7:0] cmp_sh;

    // Shadow of the mask, built from the strobes only so it never trusts the design
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mask_sh <= MASK_RST;
        end else if (i_wr && i_addr == OFS_MASK) begin
            mask_sh <= i_wdata[1:0];
        end
    end

    // Shadow of the last written compare value
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cmp_sh <= COMPARE_RST;
        end else if (i_wr && i_addr == OFS_COMPARE) begin
            cmp_sh <= i_wdata;
        end
    end

    // Register port framing and read-back
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    a_unmapped_zero: assert property (i_rd && i_addr > OFS_ASYNC |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_force_reads_zero: assert property (i_rd && i_addr == OFS_CONTROL |=> !o_rdata[FORCE_POS])
        else $error("force bit read as one");
    a_mask_read_back: assert property (i_rd && i_addr == OFS_MASK |=> o_rdata == {6'h00, mask_sh})
        else $error("mask read back wrong");
    a_compare_read_back: assert property (i_rd && i_addr == OFS_COMPARE |=> o_rdata == cmp_sh)
        else $error("compare read back wrong");

    // Requests only pass through an enabled mask bit
    a_ovf_irq_masked: assert property (o_ovf_irq |-> $past(mask_sh[OVF_POS]))
        else $error("overflow request while masked");
    a_cmp_irq_masked: assert property (o_cmp_irq |-> $past(mask_sh[CMP_POS]))
        else $error("compare request while masked");

    // Port override follows the output mode field
    a_port_override: assert property ((i_wr && i_addr == OFS_CONTROL) ##1 !(i_wr && i_addr == OFS_CONTROL)
        |-> ##1 o_compare_output_en == (|$past(i_wdata[COM_HI_POS:COM_LO_POS], 2)))
        else $error("output enable does not follow mode");
endmodule
`default_nettype wire

// *** verification/async_timer8_compare_unit_tb.sv ***
// Self-checking testbench for the 8-bit timer with one compare unit
`timescale 1ns/100ps
`default_nettype none
module async_timer8_compare_unit_tb
    import timer8_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ovf_svc = 1'b0;
    logic cmp_svc = 1'b0;
    logic xtal = 1'b0;
    logic [7:0] rdata;
    logic ovf_irq;
    logic cmp_irq;
    logic xtal_out;
    logic cout;
    logic cout_en;
    logic [7:0] d;
    logic [7:0] d0;
    int fail_count = 0;
    int checks = 0;

    async_timer8_compare_unit i_async_timer8_compare_unit (
        .i_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_ovf_service(ovf_svc), .i_cmp_service(cmp_svc), .o_ovf_irq(ovf_irq),
        .o_cmp_irq(cmp_irq), .i_crystal_pin_in(xtal), .o_crystal_pin_out(xtal_out),
        .o_compare_output(cout), .o_compare_output_en(cout_en)
    );

    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One-cycle strobes; the gap edge keeps a strobe from being set twice in one step
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        rd_reg(a);
        check(d, exp);
    endtask

    task automatic t_reset();
        for (int a = 0; a < 8; a++) begin
            rd_chk(a[2:0], 8'h00);
        end
        wr_reg(OFS_COUNT, 8'h42);
        wait_clk(20);
        rd_chk(OFS_COUNT, 8'h42);
    endtask

    task automatic t_overflow();
        wr_reg(OFS_COMPARE, 8'h80);
        wr_reg(OFS_MASK, 8'h01);
        wr_reg(OFS_COUNT, 8'hf8);
        wr_reg(OFS_CONTROL, 8'h10);
        wait_clk(30);
        wr_reg(OFS_CONTROL, 8'h00);
        rd_chk(OFS_FLAGS, 8'h01);
        check({7'h00, ovf_irq}, 8'h01);
        rd_reg(OFS_COUNT);
        check(d, 8'h18);
        wr_reg(OFS_FLAGS, 8'h01);
        rd_chk(OFS_FLAGS, 8'h00);
        check({7'h00, ovf_irq}, 8'h00);
    endtask

    task automatic t_compare();
        wr_reg(OFS_COMPARE, 8'h20);
        wr_reg(OFS_COUNT, 8'h10);
        wr_reg(OFS_MASK, 8'h02);
        wr_reg(OFS_CONTROL, 8'h10);
        for (int n = 0; n < 100 && cmp_irq !== 1'b1; n++) begin
            @(posedge clk);
        end
        wr_reg(OFS_CONTROL, 8'h00);
        check({7'h00, cmp_irq}, 8'h01);
        rd_reg(OFS_COUNT);
        check({7'h00, d > 8'h20}, 8'h01);
        rd_chk(OFS_FLAGS, 8'h02);
        @(posedge clk);
        cmp_svc <= 1'b1;
        @(posedge clk);
        cmp_svc <= 1'b0;
        rd_chk(OFS_FLAGS, 8'h00);
    endtask

    // A count write equal to the compare value hides the first match
    task automatic t_block();
        wr_reg(OFS_COMPARE, 8'h40);
        wr_reg(OFS_COUNT, 8'h40);
        wr_reg(OFS_CONTROL, 8'h10);
        wait_clk(10);
        wr_reg(OFS_CONTROL, 8'h00);
        rd_chk(OFS_FLAGS, 8'h00);
        check({7'h00, cmp_irq}, 8'h00);
    endtask

    task automatic t_ctc();
        wr_reg(OFS_COMPARE, 8'h05);
        wr_reg(OFS_COUNT, 8'h00);
        wr_reg(OFS_CONTROL, 8'h12);
        wait_clk(40);
        rd_reg(OFS_COUNT);
        check(d, 8'h05);
        wr_reg(OFS_CONTROL, 8'h02);
        rd_chk(OFS_FLAGS, 8'h02);
        wr_reg(OFS_FLAGS, 8'h03);
    endtask

    task automatic t_force();
        wr_reg(OFS_CONTROL, 8'h00);
        rd_reg(OFS_COUNT);
        d0 = d;
        check({7'h00, cout_en}, 8'h00);
        check({7'h00, cout}, 8'h00);
        // Mode first: the strobe acts with the output mode already held
        wr_reg(OFS_CONTROL, 8'h04);
        wr_reg(OFS_CONTROL, 8'h84);
        wait_clk(2);
        check({7'h00, cout}, 8'h01);
        check({7'h00, cout_en}, 8'h01);
        rd_chk(OFS_CONTROL, 8'h04);
        rd_chk(OFS_FLAGS, 8'h00);
        rd_chk(OFS_COUNT, d0);
        wr_reg(OFS_CONTROL, 8'h00);
    endtask

    // Fast pulse width: a write while stopped only reaches the buffer
    task automatic t_pwm();
        wr_reg(OFS_COMPARE, 8'h10);
        wr_reg(OFS_COUNT, 8'h00);
        wr_reg(OFS_CONTROL, 8'h0b);
        wr_reg(OFS_COMPARE, 8'h40);
        rd_chk(OFS_COMPARE, 8'h40);
        wr_reg(OFS_CONTROL, 8'h1b);
        wait_clk(20);
        wr_reg(OFS_CONTROL, 8'h0b);
        rd_chk(OFS_COUNT, 8'h16);
        rd_chk(OFS_FLAGS, 8'h02);
        check({7'h00, cout}, 8'h00);
        check({7'h00, cout_en}, 8'h01);
        wr_reg(OFS_FLAGS, 8'h03);
        wr_reg(OFS_CONTROL, 8'h00);
    endtask

    // Crystal source: the io clock must not count, each pin rise counts once
    task automatic t_async();
        wr_reg(OFS_ASYNC, 8'h01);
        wr_reg(OFS_COUNT, 8'h00);
        wr_reg(OFS_CONTROL, 8'h10);
        wait_clk(20);
        rd_chk(OFS_COUNT, 8'h00);
        wait_clk(1);
        repeat (10) begin
            xtal <= 1'b1;
            wait_clk(8);
            xtal <= 1'b0;
            wait_clk(8);
        end
        wr_reg(OFS_CONTROL, 8'h00);
        rd_chk(OFS_COUNT, 8'h0a);
        rd_chk(OFS_ASYNC, 8'h01);
        check({7'h00, xtal_out}, 8'h01);
    endtask

    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        wait_clk(20000);
        fail_count++;
        print_verdict();
    end

    initial begin
        wait_clk(3);
        srst <= 1'b0;
        t_reset();
        t_overflow();
        t_compare();
        t_block();
        t_ctc();
        t_force();
        t_pwm();
        t_async();
        print_verdict();
    end
endmodule

bind async_timer8_compare_unit timer8_asserts i_timer8_asserts (
    .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_ovf_irq(o_ovf_irq), .o_cmp_irq(o_cmp_irq), .o_compare_output_en(o_compare_output_en)
);
`default_nettype wire
